/* hw/acr_regs.svh */
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// register offsets, byte addresses, one 32-bit word each
`define ACR_OFS_FREQ_SRC      8'h00
`define ACR_OFS_CHAN_SWITCH   8'h04
`define ACR_OFS_LOOP_EN       8'h08
`define ACR_OFS_FB_SRC        8'h0c
`define ACR_OFS_FF_SRC        8'h10
`define ACR_OFS_TLIM_SRC      8'h14
`define ACR_OFS_TREF_SRC      8'h18
`define ACR_OFS_MAX_FREQ      8'h1c
`define ACR_OFS_VGAIN         8'h20
`define ACR_OFS_IGAIN         8'h24
`define ACR_OFS_FREQ_CMD      8'h40
`define ACR_OFS_FB_CMD        8'h44
`define ACR_OFS_FF_CMD        8'h48
`define ACR_OFS_TLIM_CMD      8'h4c
`define ACR_OFS_TREF_CMD      8'h50
`define ACR_OFS_VALID         8'h54

// selector codes
`define ACR_CODE_00           2'h0
`define ACR_CODE_01           2'h1
`define ACR_CODE_02           2'h2

// widths and scales
`define ACR_ADC_W             12
`define ACR_ADC_FS            12'hfff
`define ACR_GAIN_W            11
`define ACR_GAIN_MAX          11'h7d0
`define ACR_GAIN_UNITY        11'h3e8
`define ACR_CMD_W             16
`define ACR_PCT100_FS         16'h2710
`define ACR_PCT200_FS         16'h4e20
`define ACR_MAX_FREQ_RST      16'h1770

// reset values of selectors
`define ACR_SEL_RST           2'h0

`endif

/* hw/acr_pkg.sv */
`include "acr_regs.svh"

package acr_pkg;
	typedef logic [`ACR_ADC_W-1:0]  acr_adc_t;
	typedef logic [`ACR_GAIN_W-1:0] acr_gain_t;
	typedef logic [`ACR_CMD_W-1:0]  acr_cmd_t;
	typedef logic [1:0]             acr_sel_t;
	typedef logic [7:0]             acr_addr_t;
	typedef logic [31:0]            acr_word_t;
endpackage : acr_pkg

/* hw/acr_gain.sv */
`include "acr_regs.svh"

// scales one converted channel by a gain in tenths of a percent, clipped to full scale
module acr_gain (
	input  wire acr_pkg::acr_adc_t  raw,
	input  wire acr_pkg::acr_gain_t gain,
	output acr_pkg::acr_adc_t       scaled
);
	import acr_pkg::*;

	logic [`ACR_ADC_W+`ACR_GAIN_W-1:0] prod;
	logic [`ACR_ADC_W+`ACR_GAIN_W-1:0] quot;

	// divide by unity gain; saturate so a 200 % trim cannot wrap the command
	always_comb begin
		prod = raw * gain;
		quot = prod / `ACR_GAIN_UNITY;
		if (quot > {{`ACR_GAIN_W{1'b0}}, `ACR_ADC_FS})
			scaled = `ACR_ADC_FS;
		else
			scaled = quot[`ACR_ADC_W-1:0];
	end
endmodule : acr_gain

/* hw/acr_routing.sv */
// Behaviour
// [RQ1] frequency code 01 takes switch-chosen channel
// [RQ2] loop enabled: feedback 00 current, 01 voltage
// [RQ3] loop enabled: feed-forward 01 voltage, 02 current
// [RQ4] torque limit code 02 uses voltage only
// [RQ5] torque command 00 voltage, 01 current
// [RQ6] channel full scale maps to command full scale
// [RQ7] software treats maximum frequency as 200 percent
// [RQ8] each channel has its own gain
// [RQ9] software trims with gain, scales elsewhere
// [RQ10] software avoids routing one channel twice
// [RQ11] gain 0.0 to 200.0 percent multiplies channel
// [RQ12] settings take effect on next control update
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`include "acr_regs.svh"

module acr_routing (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire acr_pkg::acr_addr_t addr,
	input  wire acr_pkg::acr_word_t wdata,
	input  wire logic               wr_stb,
	input  wire logic               rd_stb,
	output acr_pkg::acr_word_t      rdata,
	input  wire acr_pkg::acr_adc_t  voltage_channel,
	input  wire acr_pkg::acr_adc_t  current_channel,
	input  wire logic               channel_switch_terminal,
	input  wire logic               ctrl_update,
	output acr_pkg::acr_cmd_t       freq_cmd,
	output logic                    freq_cmd_valid,
	output acr_pkg::acr_cmd_t       feedback_cmd,
	output logic                    feedback_valid,
	output acr_pkg::acr_cmd_t       feedforward_cmd,
	output logic                    feedforward_valid,
	output acr_pkg::acr_cmd_t       torque_limit_cmd,
	output logic                    torque_limit_valid,
	output acr_pkg::acr_cmd_t       torque_cmd,
	output logic                    torque_cmd_valid,
	output logic                    cmd_updated
);
	import acr_pkg::*;

	// software-side settings, written at any time
	acr_sel_t  frequency_source_selector_q;
	acr_sel_t  channel_switch_setting_q;
	acr_sel_t  closed_loop_enable_q;
	acr_sel_t  feedback_source_selector_q;
	acr_sel_t  feedforward_source_selector_q;
	acr_sel_t  torque_limit_source_selector_q;
	acr_sel_t  torque_reference_source_selector_q;
	acr_cmd_t  maximum_frequency_setting_q;
	acr_gain_t voltage_channel_gain_q;
	acr_gain_t current_channel_gain_q;

	// working copies that the datapath uses, loaded only on a control update
	acr_sel_t  freq_src_a_q;
	acr_sel_t  chan_sw_a_q;
	acr_sel_t  loop_en_a_q;
	acr_sel_t  fb_src_a_q;
	acr_sel_t  ff_src_a_q;
	acr_sel_t  tlim_src_a_q;
	acr_sel_t  tref_src_a_q;
	acr_cmd_t  max_freq_a_q;
	acr_gain_t gain_a_q [2];
	acr_adc_t  chan_raw [2];
	acr_adc_t  chan_scaled [2];
	logic      apply_q;

	acr_word_t wval;
	acr_gain_t gain_wr;

	assign wval    = wdata;
	assign chan_raw[0] = voltage_channel;
	assign chan_raw[1] = current_channel;

	// a gain above 200.0 % is clipped on write rather than refused
	assign gain_wr = (wval[31:`ACR_GAIN_W] != '0 || wval[`ACR_GAIN_W-1:0] > `ACR_GAIN_MAX) ?
			`ACR_GAIN_MAX : wval[`ACR_GAIN_W-1:0];   // [RQ11]

	// settings registers
	always_ff @(posedge clk) begin
		if (rst) begin
			frequency_source_selector_q        <= `ACR_SEL_RST;
			channel_switch_setting_q           <= `ACR_SEL_RST;
			closed_loop_enable_q               <= `ACR_SEL_RST;
			feedback_source_selector_q         <= `ACR_SEL_RST;
			feedforward_source_selector_q      <= `ACR_SEL_RST;
			torque_limit_source_selector_q     <= `ACR_SEL_RST;
			torque_reference_source_selector_q <= `ACR_SEL_RST;
			maximum_frequency_setting_q        <= `ACR_MAX_FREQ_RST;
			voltage_channel_gain_q             <= `ACR_GAIN_UNITY;
			current_channel_gain_q             <= `ACR_GAIN_UNITY;
		end else if (wr_stb) begin
			case (addr)
				`ACR_OFS_FREQ_SRC:    frequency_source_selector_q        <= wval[1:0];
				`ACR_OFS_CHAN_SWITCH: channel_switch_setting_q           <= wval[1:0];
				`ACR_OFS_LOOP_EN:     closed_loop_enable_q               <= wval[1:0];
				`ACR_OFS_FB_SRC:      feedback_source_selector_q         <= wval[1:0];
				`ACR_OFS_FF_SRC:      feedforward_source_selector_q      <= wval[1:0];
				`ACR_OFS_TLIM_SRC:    torque_limit_source_selector_q     <= wval[1:0];
				`ACR_OFS_TREF_SRC:    torque_reference_source_selector_q <= wval[1:0];
				`ACR_OFS_MAX_FREQ:    maximum_frequency_setting_q        <= wval[`ACR_CMD_W-1:0];
				`ACR_OFS_VGAIN:       voltage_channel_gain_q             <= gain_wr;   // [RQ8]
				`ACR_OFS_IGAIN:       current_channel_gain_q             <= gain_wr;   // [RQ8]
				default: ;
			endcase
		end
	end

	// copy settings only at an update so a half-written set never reaches the commands
	always_ff @(posedge clk) begin
		if (rst) begin
			freq_src_a_q <= `ACR_SEL_RST;
			chan_sw_a_q  <= `ACR_SEL_RST;
			loop_en_a_q  <= `ACR_SEL_RST;
			fb_src_a_q   <= `ACR_SEL_RST;
			ff_src_a_q   <= `ACR_SEL_RST;
			tlim_src_a_q <= `ACR_SEL_RST;
			tref_src_a_q <= `ACR_SEL_RST;
			max_freq_a_q <= `ACR_MAX_FREQ_RST;
			gain_a_q[0]  <= `ACR_GAIN_UNITY;
			gain_a_q[1]  <= `ACR_GAIN_UNITY;
		end else if (ctrl_update) begin   // [RQ12]
			freq_src_a_q <= frequency_source_selector_q;
			chan_sw_a_q  <= channel_switch_setting_q;
			loop_en_a_q  <= closed_loop_enable_q;
			fb_src_a_q   <= feedback_source_selector_q;
			ff_src_a_q   <= feedforward_source_selector_q;
			tlim_src_a_q <= torque_limit_source_selector_q;
			tref_src_a_q <= torque_reference_source_selector_q;
			max_freq_a_q <= maximum_frequency_setting_q;
			gain_a_q[0]  <= voltage_channel_gain_q;
			gain_a_q[1]  <= current_channel_gain_q;
		end
	end

	// outputs follow one cycle after the settings were copied
	always_ff @(posedge clk) begin
		if (rst)
			apply_q <= 1'b0;
		else
			apply_q <= ctrl_update;
	end

	// per-channel gain trim, index 0 voltage, index 1 current
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		acr_gain u_gain (
			.raw    (chan_raw[ch]),
			.gain   (gain_a_q[ch]),
			.scaled (chan_scaled[ch])
		);   // [RQ8] [RQ11]
	end

	// full-scale conversion: channel full scale lands on command full scale
	function automatic acr_cmd_t scale_to(input acr_adc_t v, input acr_cmd_t fs);
		logic [`ACR_ADC_W+`ACR_CMD_W-1:0] p;
		logic [`ACR_ADC_W+`ACR_CMD_W-1:0] q;
		p = v * fs;
		q = p / `ACR_ADC_FS;
		return q[`ACR_CMD_W-1:0];
	endfunction : scale_to

	// channel choices
	logic     freq_use_current;
	logic     freq_ok;
	logic     loop_on;
	logic     fb_ok;
	logic     ff_ok;
	logic     tlim_ok;
	logic     tref_ok;
	acr_adc_t freq_ch;
	acr_adc_t fb_ch;
	acr_adc_t ff_ch;
	acr_adc_t tref_ch;

	always_comb begin
		// switch code 00 lets the terminal choose; 01 and 02 pin one channel
		case (chan_sw_a_q)
			`ACR_CODE_00: freq_use_current = channel_switch_terminal;   // [RQ1]
			`ACR_CODE_01: freq_use_current = 1'b0;
			`ACR_CODE_02: freq_use_current = 1'b1;
			default:      freq_use_current = channel_switch_terminal;
		endcase
		freq_ok = (freq_src_a_q == `ACR_CODE_01);   // [RQ1]
		freq_ch = freq_use_current ? chan_scaled[1] : chan_scaled[0];
		loop_on = (loop_en_a_q == `ACR_CODE_01) || (loop_en_a_q == `ACR_CODE_02);
		// feedback: 00 current, 01 voltage
		case (fb_src_a_q)
			`ACR_CODE_00: begin fb_ok = loop_on; fb_ch = chan_scaled[1]; end   // [RQ2]
			`ACR_CODE_01: begin fb_ok = loop_on; fb_ch = chan_scaled[0]; end   // [RQ2]
			default:      begin fb_ok = 1'b0;    fb_ch = '0;             end
		endcase
		// feed-forward: 01 voltage, 02 current
		case (ff_src_a_q)
			`ACR_CODE_01: begin ff_ok = loop_on; ff_ch = chan_scaled[0]; end   // [RQ3]
			`ACR_CODE_02: begin ff_ok = loop_on; ff_ch = chan_scaled[1]; end   // [RQ3]
			default:      begin ff_ok = 1'b0;    ff_ch = '0;             end
		endcase
		// the limit never looks at the current channel
		tlim_ok = (tlim_src_a_q == `ACR_CODE_02);   // [RQ4]
		case (tref_src_a_q)
			`ACR_CODE_00: begin tref_ok = 1'b1; tref_ch = chan_scaled[0]; end   // [RQ5]
			`ACR_CODE_01: begin tref_ok = 1'b1; tref_ch = chan_scaled[1]; end   // [RQ5]
			default:      begin tref_ok = 1'b0; tref_ch = '0;             end
		endcase
	end

	// command registers change only at an update, so a setting change cannot glitch them;
	// both channels may feed several commands, nothing here prevents it
	always_ff @(posedge clk) begin
		if (rst) begin
			freq_cmd           <= '0;
			freq_cmd_valid     <= 1'b0;
			feedback_cmd       <= '0;
			feedback_valid     <= 1'b0;
			feedforward_cmd    <= '0;
			feedforward_valid  <= 1'b0;
			torque_limit_cmd   <= '0;
			torque_limit_valid <= 1'b0;
			torque_cmd         <= '0;
			torque_cmd_valid   <= 1'b0;
		end else if (apply_q) begin   // [RQ12]
			freq_cmd           <= freq_ok ? scale_to(freq_ch, max_freq_a_q) : '0;   // [RQ6]
			freq_cmd_valid     <= freq_ok;
			feedback_cmd       <= fb_ok ? scale_to(fb_ch, `ACR_PCT100_FS) : '0;   // [RQ6]
			feedback_valid     <= fb_ok;
			feedforward_cmd    <= ff_ok ? scale_to(ff_ch, `ACR_PCT100_FS) : '0;   // [RQ6]
			feedforward_valid  <= ff_ok;
			torque_limit_cmd   <= tlim_ok ? scale_to(chan_scaled[0], `ACR_PCT200_FS) : '0;   // [RQ4] [RQ6]
			torque_limit_valid <= tlim_ok;
			torque_cmd         <= tref_ok ? scale_to(tref_ch, `ACR_PCT200_FS) : '0;   // [RQ6]
			torque_cmd_valid   <= tref_ok;
		end
	end

	// one-cycle marker that fresh commands stand on the outputs
	always_ff @(posedge clk) begin
		if (rst)
			cmd_updated <= 1'b0;
		else
			cmd_updated <= apply_q;
	end

	// read data one cycle after the strobe; unmapped or idle reads give zero
	always_ff @(posedge clk) begin
		if (rst || !rd_stb) begin
			rdata <= '0;
		end else begin
			case (addr)
				`ACR_OFS_FREQ_SRC:    rdata <= {30'h0, frequency_source_selector_q};
				`ACR_OFS_CHAN_SWITCH: rdata <= {30'h0, channel_switch_setting_q};
				`ACR_OFS_LOOP_EN:     rdata <= {30'h0, closed_loop_enable_q};
				`ACR_OFS_FB_SRC:      rdata <= {30'h0, feedback_source_selector_q};
				`ACR_OFS_FF_SRC:      rdata <= {30'h0, feedforward_source_selector_q};
				`ACR_OFS_TLIM_SRC:    rdata <= {30'h0, torque_limit_source_selector_q};
				`ACR_OFS_TREF_SRC:    rdata <= {30'h0, torque_reference_source_selector_q};
				`ACR_OFS_MAX_FREQ:    rdata <= {16'h0, maximum_frequency_setting_q};
				`ACR_OFS_VGAIN:       rdata <= {21'h0, voltage_channel_gain_q};
				`ACR_OFS_IGAIN:       rdata <= {21'h0, current_channel_gain_q};
				`ACR_OFS_FREQ_CMD:    rdata <= {16'h0, freq_cmd};
				`ACR_OFS_FB_CMD:      rdata <= {16'h0, feedback_cmd};
				`ACR_OFS_FF_CMD:      rdata <= {16'h0, feedforward_cmd};
				`ACR_OFS_TLIM_CMD:    rdata <= {16'h0, torque_limit_cmd};
				`ACR_OFS_TREF_CMD:    rdata <= {16'h0, torque_cmd};
				`ACR_OFS_VALID:       rdata <= {27'h0, torque_cmd_valid, torque_limit_valid,
						feedforward_valid, feedback_valid, freq_cmd_valid};
				default:              rdata <= '0;
			endcase
		end
	end
endmodule : acr_routing

/* testbench/acr_routing_properties.sv */
`include "acr_regs.svh"

// watches the command outputs against the update tick
module acr_routing_chk (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              ctrl_update,
	input wire acr_pkg::acr_cmd_t freq_cmd,
	input wire logic              freq_cmd_valid,
	input wire acr_pkg::acr_cmd_t feedback_cmd,
	input wire logic              feedback_valid,
	input wire acr_pkg::acr_cmd_t feedforward_cmd,
	input wire logic              feedforward_valid,
	input wire acr_pkg::acr_cmd_t torque_limit_cmd,
	input wire logic              torque_limit_valid,
	input wire acr_pkg::acr_cmd_t torque_cmd,
	input wire logic              torque_cmd_valid,
	input wire logic              cmd_updated
);
	timeunit 1ns;
	timeprecision 1ps;
	import acr_pkg::*;

	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	// commands only move in the few cycles after a tick, so a missed apply shows up as drift
	a_cmd_hold: assert property (!$past(rst) && !$past(ctrl_update) && !$past(ctrl_update, 2)
		&& !$past(ctrl_update, 3) |-> $stable({freq_cmd, feedback_cmd, feedforward_cmd, torque_limit_cmd, torque_cmd}))
		else $error("command moved without an update tick");
	a_valid_hold: assert property (!$past(rst) && !$past(ctrl_update) && !$past(ctrl_update, 2)
		&& !$past(ctrl_update, 3) |-> $stable({freq_cmd_valid, feedback_valid, feedforward_valid,
		torque_limit_valid, torque_cmd_valid}))
		else $error("valid moved without an update tick");
	a_upd_cause: assert property (cmd_updated |-> $past(ctrl_update, 2) || $past(ctrl_update, 3))
		else $error("update pulse without a tick");
	a_reset_clear: assert property ($past(rst) |-> !cmd_updated && freq_cmd == '0 && torque_cmd == '0)
		else $error("outputs not cleared by reset");
	// full scale of each command except freq_cmd is a hard ceiling whatever the gain
	a_fb_scale: assert property (feedback_cmd <= `ACR_PCT100_FS)
		else $error("feedback above full scale");
	a_ff_scale: assert property (feedforward_cmd <= `ACR_PCT100_FS)
		else $error("feed-forward above full scale");
	a_tlim_scale: assert property (torque_limit_cmd <= `ACR_PCT200_FS)
		else $error("torque limit above full scale");
	a_tref_scale: assert property (torque_cmd <= `ACR_PCT200_FS)
		else $error("torque command above full scale");
endmodule : acr_routing_chk

bind acr_routing acr_routing_chk chk (.clk, .rst, .ctrl_update, .freq_cmd, .freq_cmd_valid, .feedback_cmd,
	.feedback_valid, .feedforward_cmd, .feedforward_valid, .torque_limit_cmd, .torque_limit_valid,
	.torque_cmd, .torque_cmd_valid, .cmd_updated);

/* testbench/acr_routing_bench.sv */
`include "acr_regs.svh"

module acr_routing_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import acr_pkg::*;

	logic      clk, rst, wr_stb, rd_stb, sw_term, ctrl_update, cmd_updated;
	logic      fq_ok, fb_ok, ff_ok, tl_ok, tq_ok;
	acr_addr_t addr;
	acr_word_t wdata, rdata;
	acr_adc_t  v_in, i_in;
	acr_cmd_t  fq, fb, ff, tl, tq;
	int        failures, check_count;

	acr_routing dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .voltage_channel(v_in), .current_channel(i_in), .channel_switch_terminal(sw_term),
		.ctrl_update(ctrl_update), .freq_cmd(fq), .freq_cmd_valid(fq_ok), .feedback_cmd(fb),
		.feedback_valid(fb_ok), .feedforward_cmd(ff), .feedforward_valid(ff_ok), .torque_limit_cmd(tl),
		.torque_limit_valid(tl_ok), .torque_cmd(tq), .torque_cmd_valid(tq_ok), .cmd_updated(cmd_updated));

	// 250 MHz
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input acr_word_t got, input acr_word_t exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// expected scaling, gain in tenths of a percent, clipped at converter full scale
	function automatic acr_word_t sc(input acr_adc_t raw, input int gain, input int fs);
		int g;
		g = int'(raw) * gain / 1000;
		if (g > 4095) g = 4095;
		return acr_word_t'(g * fs / 4095);
	endfunction : sc

	task automatic wr(input acr_addr_t a, input int d);
		@(posedge clk);
		addr <= a;
		wdata <= acr_word_t'(d);
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr

	task automatic rd_chk(input acr_addr_t a, input acr_word_t e);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd_chk

	// one tick, then wait for the done pulse; bounded so a dead update path cannot hang
	task automatic upd();
		int n;
		n = 0;
		@(posedge clk);
		ctrl_update <= 1'b1;
		@(posedge clk);
		ctrl_update <= 1'b0;
		#1;
		while (cmd_updated !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1 n++;
		end
		chk(n < 8, 1);
		chk(n, 1); // commands and the marker land two edges after the tick
	endtask : upd

	task automatic t_regs();
		rd_chk(`ACR_OFS_VGAIN, 32'h3e8);
		rd_chk(`ACR_OFS_MAX_FREQ, 32'h1770);
		rd_chk(8'h3c, 32'h0);
		wr(`ACR_OFS_VGAIN, 32'h900);
		rd_chk(`ACR_OFS_VGAIN, 32'h7d0);
		wr(`ACR_OFS_VGAIN, 1000); // back to unity, range conversion is left to start/end scaling
	endtask : t_regs

	task automatic t_torque();
		wr(`ACR_OFS_TREF_SRC, 0);
		upd();
		chk(tq, sc(v_in, 1000, 20000));
		wr(`ACR_OFS_TREF_SRC, 1);
		repeat (4) @(posedge clk);
		#1 chk(tq, sc(v_in, 1000, 20000));
		upd();
		chk(tq, sc(i_in, 1000, 20000));
		chk(tq_ok, 1);
	endtask : t_torque

	task automatic t_loop();
		wr(`ACR_OFS_LOOP_EN, 0);
		upd();
		chk({fb_ok, ff_ok}, 0);
		for (int m = 1; m < 3; m++) begin
			wr(`ACR_OFS_LOOP_EN, m);
			wr(`ACR_OFS_FB_SRC, m - 1);
			wr(`ACR_OFS_FF_SRC, m);
			upd();
			chk(fb, sc(m == 1 ? i_in : v_in, 1000, 10000));
			chk(ff, sc(m == 1 ? v_in : i_in, 1000, 10000));
			chk({fb_ok, ff_ok}, 3);
		end
	endtask : t_loop

	// changing the current channel must not disturb the limit
	task automatic t_tlim();
		wr(`ACR_OFS_MAX_FREQ, 32'h4e20); // maximum frequency programmed as 200 percent
		wr(`ACR_OFS_TLIM_SRC, 2);
		upd();
		chk(tl, sc(v_in, 1000, 20000));
		chk(tl_ok, 1);
		@(posedge clk);
		i_in <= 12'h123;
		upd();
		chk(tl, sc(v_in, 1000, 20000));
	endtask : t_tlim

	task automatic t_freq();
		wr(`ACR_OFS_FREQ_SRC, 1);
		wr(`ACR_OFS_MAX_FREQ, 32'h1388);
		for (int c = 0; c < 4; c++) begin
			for (int t = 0; t < 2; t++) begin
				wr(`ACR_OFS_CHAN_SWITCH, c);
				sw_term <= t[0];
				upd();
				chk(fq, sc((c == 1 || (c != 2 && t == 0)) ? v_in : i_in, 1000, 5000));
				chk(fq_ok, 1);
			end
		end
	endtask : t_freq

	task automatic t_gain();
		wr(`ACR_OFS_VGAIN, 500);
		wr(`ACR_OFS_IGAIN, 2000);
		wr(`ACR_OFS_TREF_SRC, 0);
		upd();
		chk(tq, sc(v_in, 500, 20000));
		wr(`ACR_OFS_TREF_SRC, 1);
		upd();
		chk(tq, sc(i_in, 2000, 20000));
		// a 200 % trim on a large input must saturate, not wrap
		@(posedge clk);
		i_in <= 12'hc00;
		upd();
		chk(tq, 32'h4e20);
		wr(`ACR_OFS_IGAIN, 0);
		upd();
		chk(tq, 0);
		wr(`ACR_OFS_VGAIN, 1000);
		wr(`ACR_OFS_IGAIN, 1000);
	endtask : t_gain

	task automatic t_full();
		v_in <= 12'hfff;
		i_in <= 12'hfff;
		wr(`ACR_OFS_FB_SRC, 1); // voltage feeds feedback and limit on purpose here
		upd();
		chk({fq, fb}, {16'h1388, 16'h2710});
		chk({tl, tq}, {16'h4e20, 16'h4e20});
		rd_chk(`ACR_OFS_FREQ_CMD, 32'h1388);
		rd_chk(`ACR_OFS_TREF_CMD, 32'h4e20);
		rd_chk(`ACR_OFS_VALID, 32'h1f);
	endtask : t_full

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : tally_and_finish

	initial begin
		{rst, wr_stb, rd_stb, sw_term, ctrl_update} = 5'h10;
		{addr, wdata} = '0;
		v_in = 12'hc35;
		i_in = 12'h5a7;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_torque();
		t_loop();
		t_tlim();
		t_freq();
		t_gain();
		t_full();
		tally_and_finish();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
endmodule : acr_routing_bench
